// ==== core/hub_strap_map.svh ====
// timing counts and reset values for the port disable strap decoder
`ifndef HUB_STRAP_MAP_SVH
`define HUB_STRAP_MAP_SVH

// settle time after reset release before straps are latched, in ns
`define STRAP_SETTLE_NS     16
// clock period in ns
`define STRAP_CLK_PERIOD_NS 4
// least time rounds up to whole cycles
`define STRAP_SETTLE_CYCLES ((`STRAP_SETTLE_NS + `STRAP_CLK_PERIOD_NS - 1) / `STRAP_CLK_PERIOD_NS)
// strap level that requests disabling
`define STRAP_DISABLE_LEVEL 1'h1
// reset value of the enable mask: nothing enabled until latched
`define PORT_ENABLE_RESET   4'h0
// reset value of a logical port number: zero means unmapped
`define PORT_NUMBER_RESET   3'h0
// reset value of the enabled port count
`define ENABLED_COUNT_RESET 3'h0
// reset value of the settle countdown
`define SETTLE_COUNT_RESET  4'h0

`endif

// ==== core/hub_strap_pkg.sv ====
// types shared by the port disable strap decoder
package hub_strap_pkg;

    // the two strap levels of one downstream port
    typedef struct packed {
        logic dpStrap;   // strap on the D+ pin
        logic dmStrap;   // strap on the D- pin
    } strap_pair_t;

    // logical number (1..4) for each physical port, 0 when disabled
    typedef logic [2:0] port_number_t;

    // decoder phases
    typedef enum logic [1:0] {
        ST_RESET  = 2'b00,
        ST_SETTLE = 2'b01,
        ST_LATCH  = 2'b10,
        ST_DONE   = 2'b11
    } strap_state_t;

endpackage

// ==== core/hub_port_disable_straps.sv ====
// reset-time decoding of the downstream port disable straps
//
// Functional notes
// - port 1 disabled only if both straps high
// - port 2 disabled only if both straps high
// - port 3 disabled only if both straps high
// - port 4 disabled only if both straps high
// - port 4 D- strap 1 disables only with D+ strap also 1, 0 enables
// - enabled ports renumbered contiguously toward host
`timescale 1ns/1ps
`include "hub_strap_map.svh"

module hub_port_disable_straps
#(
    parameter int NUM_PORTS = 4   // downstream ports served
)
(
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        port1_dp_disable_strap,
    input  wire logic                        port1_dm_disable_strap,
    input  wire logic                        port2_dp_disable_strap,
    input  wire logic                        port2_dm_disable_strap,
    input  wire logic                        port3_dp_disable_strap,
    input  wire logic                        port3_dm_disable_strap,
    input  wire logic                        port4_dp_disable_strap,
    input  wire logic                        port4_dm_disable_strap,
    input  wire logic                        flexSwapRequest,
    input  wire logic                        port1_power_enable,
    input  wire logic                        port1_overcurrent_sense_n,
    output logic                             strapsValid,
    output logic [NUM_PORTS-1:0]             portEnable,
    output hub_strap_pkg::port_number_t      portNumber1,
    output hub_strap_pkg::port_number_t      portNumber2,
    output hub_strap_pkg::port_number_t      portNumber3,
    output hub_strap_pkg::port_number_t      portNumber4,
    output logic [2:0]                       enabledCount,
    output logic                             flexSwapActive,
    output logic                             powerControllerPresent
);

    // only the four-port arrangement is served: refused at elaboration
    if (NUM_PORTS != 4)
    begin
        $error("hub_port_disable_straps serves exactly four ports");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: straps are board pins, outside the clock domain

    logic [9:0] pinMeta;    // first stage, read only by second stage
    logic [9:0] pinSync;    // second stage, safe to decode
    wire  [9:0] pinRaw = {port1_overcurrent_sense_n, port1_power_enable,
                          port4_dm_disable_strap, port4_dp_disable_strap,
                          port3_dm_disable_strap, port3_dp_disable_strap,
                          port2_dm_disable_strap, port2_dp_disable_strap,
                          port1_dm_disable_strap, port1_dp_disable_strap};

    // two-flop synchroniser on every strap-like pin
    always_ff @(posedge clock)
    begin
        pinMeta <= pinRaw;
        pinSync <= pinMeta;
    end

    logic swapMeta;   // first stage of swap request
    logic swapSync;   // second stage of swap request

    // swap selection is a pin too
    always_ff @(posedge clock)
    begin
        swapMeta <= flexSwapRequest;
        swapSync <= swapMeta;
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap decode: a port is off only when both of its straps are high

    hub_strap_pkg::strap_pair_t pair1;   // port 1 straps
    hub_strap_pkg::strap_pair_t pair2;   // port 2 straps
    hub_strap_pkg::strap_pair_t pair3;   // port 3 straps
    hub_strap_pkg::strap_pair_t pair4;   // port 4 straps

    assign pair1 = '{dpStrap: pinSync[0], dmStrap: pinSync[1]};
    assign pair2 = '{dpStrap: pinSync[2], dmStrap: pinSync[3]};
    assign pair3 = '{dpStrap: pinSync[4], dmStrap: pinSync[5]};
    assign pair4 = '{dpStrap: pinSync[6], dmStrap: pinSync[7]};

    wire disable1 = (pair1.dpStrap == `STRAP_DISABLE_LEVEL)
                  & (pair1.dmStrap == `STRAP_DISABLE_LEVEL);
    wire disable2 = (pair2.dpStrap == `STRAP_DISABLE_LEVEL)
                  & (pair2.dmStrap == `STRAP_DISABLE_LEVEL);
    wire disable3 = (pair3.dpStrap == `STRAP_DISABLE_LEVEL)
                  & (pair3.dmStrap == `STRAP_DISABLE_LEVEL);
    wire dp4Off   = (pair4.dpStrap == `STRAP_DISABLE_LEVEL);
    wire dm4Off   = (pair4.dmStrap == `STRAP_DISABLE_LEVEL);
    wire disable4 = dp4Off & dm4Off;

    // decoded enable mask, bit n is physical port n+1
    wire [3:0] enableNext = ~{disable4, disable3, disable2, disable1};

    // both port 1 power pins high marks an external power controller
    wire powerCtrlNext = pinSync[8] & pinSync[9];

    ////////////////////////////////////////////////////////////////////////////
    // contiguous renumbering: each enabled port counts enabled ports below it

    wire [2:0] num1Next = enableNext[0] ? 3'h1 : `PORT_NUMBER_RESET;
    wire [2:0] below2   = {2'h0, enableNext[0]};
    wire [2:0] below3   = below2 + {2'h0, enableNext[1]};
    wire [2:0] below4   = below3 + {2'h0, enableNext[2]};
    wire [2:0] countAll = below4 + {2'h0, enableNext[3]};
    wire [2:0] num2Next = enableNext[1] ? below2 + 3'h1 : `PORT_NUMBER_RESET;
    wire [2:0] num3Next = enableNext[2] ? below3 + 3'h1 : `PORT_NUMBER_RESET;
    wire [2:0] num4Next = enableNext[3] ? below4 + 3'h1 : `PORT_NUMBER_RESET;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: wait for synchronisers to settle, then latch once

    hub_strap_pkg::strap_state_t state_reg;    // current phase
    hub_strap_pkg::strap_state_t state_next;   // next phase
    logic [3:0]                  settle_reg;   // settle countdown
    logic [3:0]                  settle_next;  // next countdown

    wire latchNow = (state_reg == hub_strap_pkg::ST_LATCH);

    // phase and countdown selection
    always_comb
    begin
        state_next  = state_reg;
        settle_next = settle_reg;
        case (state_reg)
            hub_strap_pkg::ST_RESET:
            begin
                // first cycle after release: start counting
                settle_next = 4'(`STRAP_SETTLE_CYCLES);
                state_next  = hub_strap_pkg::ST_SETTLE;
            end
            hub_strap_pkg::ST_SETTLE:
            begin
                // pins pass the synchroniser before they count
                if (settle_reg <= 4'h1)
                    state_next = hub_strap_pkg::ST_LATCH;
                else
                    settle_next = settle_reg - 4'h1;
            end
            hub_strap_pkg::ST_LATCH:
            begin
                state_next = hub_strap_pkg::ST_DONE;
            end
            hub_strap_pkg::ST_DONE:
            begin
                // hold here until the next reset
                state_next = hub_strap_pkg::ST_DONE;
            end
            default:
            begin
                state_next = hub_strap_pkg::ST_RESET;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state_reg  <= hub_strap_pkg::ST_RESET;
            settle_reg <= `SETTLE_COUNT_RESET;
        end
        else
        begin
            state_reg  <= state_next;
            settle_reg <= settle_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // latched results: captured in the single latch cycle only

    // decoded straps, number map and counts
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            portEnable   <= `PORT_ENABLE_RESET;
            portNumber1  <= `PORT_NUMBER_RESET;
            portNumber2  <= `PORT_NUMBER_RESET;
            portNumber3  <= `PORT_NUMBER_RESET;
            portNumber4  <= `PORT_NUMBER_RESET;
            enabledCount <= `ENABLED_COUNT_RESET;
        end
        else if (latchNow)
        begin
            // later pin changes are ignored until reset
            portEnable   <= enableNext;
            portNumber1  <= num1Next;
            portNumber2  <= num2Next;
            portNumber3  <= num3Next;
            portNumber4  <= num4Next;
            enabledCount <= countAll;
        end
    end

    // swap selection and power controller detect, same latch moment
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            flexSwapActive         <= 1'h0;
            powerControllerPresent <= 1'h0;
            strapsValid            <= 1'h0;
        end
        else if (latchNow)
        begin
            flexSwapActive         <= swapSync;
            powerControllerPresent <= powerCtrlNext;
            strapsValid            <= 1'h1;
        end
    end

endmodule

// ==== dv/hub_port_disable_straps_asserts.sv ====
// concurrent checks on the strap decoder ports
`timescale 1ns/1ps
module hub_port_disable_straps_asserts
(
    input wire logic                        clock,
    input wire logic                        nrst,
    input wire logic                        port1_dp_disable_strap,
    input wire logic                        port1_dm_disable_strap,
    input wire logic                        port2_dp_disable_strap,
    input wire logic                        port2_dm_disable_strap,
    input wire logic                        port3_dp_disable_strap,
    input wire logic                        port3_dm_disable_strap,
    input wire logic                        port4_dp_disable_strap,
    input wire logic                        port4_dm_disable_strap,
    input wire logic                        flexSwapRequest,
    input wire logic                        strapsValid,
    input wire logic [3:0]                  portEnable,
    input wire hub_strap_pkg::port_number_t portNumber1,
    input wire hub_strap_pkg::port_number_t portNumber4,
    input wire logic [2:0]                  enabledCount,
    input wire logic                        flexSwapActive
);
    // one domain, checks idle in reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    // latch decode per port
    property p_port1; $rose(strapsValid) |->
        portEnable[0] == !(port1_dp_disable_strap && port1_dm_disable_strap); endproperty
    a_port1: assert property (p_port1) else $error("port 1 enable wrong");
    property p_port2; $rose(strapsValid) |->
        portEnable[1] == !(port2_dp_disable_strap && port2_dm_disable_strap); endproperty
    a_port2: assert property (p_port2) else $error("port 2 enable wrong");
    property p_port3; $rose(strapsValid) |->
        portEnable[2] == !(port3_dp_disable_strap && port3_dm_disable_strap); endproperty
    a_port3: assert property (p_port3) else $error("port 3 enable wrong");
    property p_port4; $rose(strapsValid) |->
        portEnable[3] == !(port4_dp_disable_strap && port4_dm_disable_strap); endproperty
    a_port4: assert property (p_port4) else $error("port 4 enable wrong");
    // renumbering and latch timing
    property p_count; strapsValid |-> enabledCount == $countones(portEnable); endproperty
    a_count: assert property (p_count) else $error("enabled count wrong");
    property p_last; strapsValid |->
        portNumber4 == (portEnable[3] ? enabledCount : 3'h0); endproperty
    a_last: assert property (p_last) else $error("port 4 number wrong");
    property p_first; strapsValid |-> portNumber1 == {2'h0, portEnable[0]}; endproperty
    a_first: assert property (p_first) else $error("port 1 number wrong");
    property p_swap; $rose(strapsValid) |-> flexSwapActive == flexSwapRequest; endproperty
    a_swap: assert property (p_swap) else $error("swap not latched");
    property p_hold; strapsValid && $past(strapsValid) |->
        $stable(portEnable) && $stable(flexSwapActive); endproperty
    a_hold: assert property (p_hold) else $error("latched value moved");
    property p_when; $rose(nrst) |-> !strapsValid [*6] ##1 strapsValid; endproperty
    a_when: assert property (p_when) else $error("latch edge wrong");
endmodule

bind hub_port_disable_straps hub_port_disable_straps_asserts chk (.clock, .nrst,
    .port1_dp_disable_strap, .port1_dm_disable_strap, .port2_dp_disable_strap,
    .port2_dm_disable_strap, .port3_dp_disable_strap, .port3_dm_disable_strap,
    .port4_dp_disable_strap, .port4_dm_disable_strap, .flexSwapRequest, .strapsValid,
    .portEnable, .portNumber1, .portNumber4, .enabledCount, .flexSwapActive);

// ==== dv/strap_board.sv ====
// board strap resistors and power pin pull-ups
`timescale 1ns/1ps
module strap_board
(
    input  wire hub_strap_pkg::strap_pair_t [3:0] level,     // fitted strap levels
    input  wire logic [1:0]                     pull,      // power pin pull-ups
    output logic [7:0]                          strapPins, // dp high bit per port
    output logic [1:0]                          powerPins  // enable, overcurrent
);
    // both straps high only where a port is to be disabled
    assign strapPins = level;
    // power controller pins pulled up at power-on
    assign powerPins = pull;
endmodule

// ==== dv/hub_port_disable_straps_tb_top.sv ====
// self-checking bench for the strap decoder
`timescale 1ns/1ps
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errTotal++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module hub_port_disable_straps_tb_top;
    logic clock;
    logic nrst;
    logic flexSwapRequest;
    hub_strap_pkg::strap_pair_t [3:0] level;
    logic [1:0] pull;
    logic [7:0] pins;
    logic [1:0] pwr;
    logic strapsValid;
    logic flexSwapActive;
    logic powerControllerPresent;
    logic [3:0] portEnable;
    logic [2:0] enabledCount;
    hub_strap_pkg::port_number_t n1, n2, n3, n4;
    int errTotal = 0;
    int numChecks = 0;
    strap_board board (.level(level), .pull(pull), .strapPins(pins), .powerPins(pwr));
    hub_port_disable_straps DUT (.clock(clock), .nrst(nrst),
        .port1_dp_disable_strap(pins[1]), .port1_dm_disable_strap(pins[0]),
        .port2_dp_disable_strap(pins[3]), .port2_dm_disable_strap(pins[2]),
        .port3_dp_disable_strap(pins[5]), .port3_dm_disable_strap(pins[4]),
        .port4_dp_disable_strap(pins[7]), .port4_dm_disable_strap(pins[6]),
        .flexSwapRequest(flexSwapRequest), .port1_power_enable(pwr[1]),
        .port1_overcurrent_sense_n(pwr[0]), .strapsValid(strapsValid),
        .portEnable(portEnable), .portNumber1(n1), .portNumber2(n2), .portNumber3(n3),
        .portNumber4(n4), .enabledCount(enabledCount), .flexSwapActive(flexSwapActive),
        .powerControllerPresent(powerControllerPresent));
    ////////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial
    begin
        clock = 1'h0;
        forever #2 clock = ~clock;
    end
    // verdict and end of run
    task testDone();
        if (errTotal == 0 && numChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // reset with given straps, await latch, check, then move pins and recheck
    task automatic run_case(input logic [7:0] lv, input logic [1:0] pw, input logic sw);
        hub_strap_pkg::strap_pair_t [3:0] s;
        logic [3:0] en;
        logic [2:0] n;
        logic [11:0] num;
        int k;
        s = lv;
        n = 3'h0;
        for (int i = 0; i < 4; i++)
        begin
            en[i] = !(s[i].dpStrap && s[i].dmStrap);
            n = n + {2'h0, en[i]};
            num[3*i +: 3] = en[i] ? n : 3'h0;
        end
        @(posedge clock);
        nrst <= 1'h0;
        level <= lv;
        pull <= pw;
        flexSwapRequest <= sw;
        repeat (2) @(posedge clock);
        nrst <= 1'h1;
        for (int r = 0; r < 2; r++)
        begin
            k = 0;
            while (strapsValid !== 1'h1 && k < 20)
            begin
                @(posedge clock);
                #1;
                k++;
            end
            `CHK(k < 20, 1'h1)
            `CHK(portEnable, en)
            `CHK({n4, n3, n2, n1}, num)
            `CHK(enabledCount, n)
            `CHK(flexSwapActive, sw)
            `CHK(powerControllerPresent, &pw)
            // later pin changes must be ignored
            @(posedge clock);
            level <= ~lv;
            pull <= ~pw;
            flexSwapRequest <= ~sw;
            repeat (10) @(posedge clock);
        end
    endtask
    // test sequence
    initial
    begin
        nrst = 1'h0;
        level = 8'h00;
        pull = 2'h0;
        flexSwapRequest = 1'h0;
        run_case(8'h00, 2'h3, 1'h1);
        run_case(8'h0C, 2'h2, 1'h0);
        run_case(8'hFF, 2'h1, 1'h1);
        run_case(8'hAA, 2'h0, 1'h0);
        run_case(8'h55, 2'h3, 1'h0);
        run_case(8'hC3, 2'h3, 1'h1);
        run_case(8'h30, 2'h0, 1'h1);
        testDone();
    end
    // watchdog
    initial
    begin
        repeat (2000) @(posedge clock);
        errTotal++;
        testDone();
    end
endmodule
